// [src/lcmfc_channel.sv]
// one sink channel: on/off, soft-start ramp, open/short deglitch, hiccup
// assumes open/short flags are comparator levels synchronous to clk_sys_in
`timescale 1ns/1ps
module lcmfc_channel #(
    parameter int SS_CYC = lcmfc_pkg::SOFT_START_CYC,
    parameter int SH_CYC = lcmfc_pkg::SHORT_DG_CYC,
    parameter int OP_CYC = lcmfc_pkg::OPEN_DG_CYC,
    parameter int HC_CYC = lcmfc_pkg::HICCUP_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic dim_in,
    input wire logic open_det_in,
    input wire logic short_det_in,
    output logic sink_on_out,
    output logic [lcmfc_pkg::RAMP_W-1:0] ramp_level_out,
    output logic fault_out
);
    import lcmfc_pkg::*;
    typedef struct packed {
        lcmfc_ch_state_t st;
        logic [TMR_W-1:0] ss_cnt;
        logic [TMR_W-1:0] op_cnt;
        logic [TMR_W-1:0] sh_cnt;
        logic [4:0] op_pulses;
        logic [4:0] sh_pulses;
        logic [TMR_W-1:0] hc_cnt;
        logic dim_d;
        logic sink;
        logic [RAMP_W-1:0] ramp;
    } lcmfc_ch_t;
    lcmfc_ch_t cur_ff, nxt_ff;
    logic fall;
    logic op_hit, sh_hit;

    always_comb
    begin
        nxt_ff = cur_ff;
        fall = cur_ff.dim_d & ~dim_in;
        op_hit = 1'b0;
        sh_hit = 1'b0;
        nxt_ff.dim_d = dim_in;
        unique case (cur_ff.st)
            LCMFC_CH_OFF:
            begin
                nxt_ff.ss_cnt = '0;
                nxt_ff.ramp = '0;
                if (run_in)
                begin
                    nxt_ff.st = LCMFC_CH_RUN;
                end
            end
            LCMFC_CH_RUN:
            begin
                // ramp advances only while conducting, so it tracks lit time
                if (dim_in && cur_ff.ss_cnt < TMR_W'(SS_CYC)) // [R2]
                begin
                    nxt_ff.ss_cnt = cur_ff.ss_cnt + 1'b1;
                end
                nxt_ff.ramp = (cur_ff.ss_cnt >= TMR_W'(SS_CYC)) ? RAMP_FULL :
                    RAMP_W'((cur_ff.ss_cnt * 256) / SS_CYC); // [R2]
                // continuous time counts while lit; pulse counts per cycle
                if (dim_in && open_det_in)
                begin
                    nxt_ff.op_cnt = cur_ff.op_cnt + 1'b1;
                end
                else if (!dim_in && !fall)
                begin
                    nxt_ff.op_cnt = '0;
                end
                if (dim_in && short_det_in)
                begin
                    nxt_ff.sh_cnt = cur_ff.sh_cnt + 1'b1;
                end
                else if (!dim_in && !fall)
                begin
                    nxt_ff.sh_cnt = '0;
                end
                if (fall)
                begin
                    nxt_ff.op_pulses = (cur_ff.op_cnt != '0) ?
                        cur_ff.op_pulses + 1'b1 : '0;
                    nxt_ff.sh_pulses = (cur_ff.sh_cnt != '0) ?
                        cur_ff.sh_pulses + 1'b1 : '0;
                    nxt_ff.op_cnt = '0;
                    nxt_ff.sh_cnt = '0;
                end
                if (dim_in && !open_det_in)
                begin
                    nxt_ff.op_cnt = '0;
                end
                if (dim_in && !short_det_in)
                begin
                    nxt_ff.sh_cnt = '0;
                end
                sh_hit = (cur_ff.sh_cnt >= TMR_W'(SH_CYC)) ||
                    (cur_ff.sh_pulses >= 5'(DG_PULSES)); // [R18]
                op_hit = (cur_ff.op_cnt >= TMR_W'(OP_CYC)) ||
                    (cur_ff.op_pulses >= 5'(DG_PULSES)); // [R19]
                if (sh_hit || op_hit) // [R14]
                begin
                    nxt_ff.st = LCMFC_CH_HICCUP;
                    nxt_ff.hc_cnt = '0;
                end
                if (!run_in)
                begin
                    nxt_ff.st = LCMFC_CH_OFF;
                end
            end
            LCMFC_CH_HICCUP:
            begin
                nxt_ff.hc_cnt = cur_ff.hc_cnt + 1'b1;
                nxt_ff.ramp = '0;
                if (cur_ff.hc_cnt == TMR_W'(HC_CYC - 1))
                begin
                    // retest: clear history; a persisting fault re-trips
                    nxt_ff.st = LCMFC_CH_RUN; // [R15]
                    nxt_ff.ss_cnt = '0;
                    nxt_ff.op_cnt = '0;
                    nxt_ff.sh_cnt = '0;
                    nxt_ff.op_pulses = '0;
                    nxt_ff.sh_pulses = '0;
                end
                if (!run_in)
                begin
                    nxt_ff.st = LCMFC_CH_OFF;
                end
            end
        endcase
        if (nxt_ff.st != LCMFC_CH_RUN)
        begin
            nxt_ff.op_cnt = '0;
            nxt_ff.sh_cnt = '0;
        end
        nxt_ff.sink = (nxt_ff.st == LCMFC_CH_RUN) && dim_in; // [R5] [R8]
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    assign sink_on_out = cur_ff.sink;
    assign ramp_level_out = cur_ff.ramp;
    assign fault_out = (cur_ff.st == LCMFC_CH_HICCUP);

    chk_sink_follows: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        ($past(cur_ff.st) == LCMFC_CH_RUN && cur_ff.st == LCMFC_CH_RUN)
        |-> (sink_on_out == $past(dim_in))) // [R5]
        else $error("sink does not follow dim input");
    chk_hiccup_len: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (fault_out && run_in && cur_ff.hc_cnt < TMR_W'(HC_CYC - 1))
        |=> fault_out) // [R14]
        else $error("hiccup ended early");
    chk_hiccup_sink_off: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        fault_out |-> ##1 (!sink_on_out || !fault_out)) // [R14]
        else $error("sink on during hiccup");
    chk_short_trip: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (cur_ff.st == LCMFC_CH_RUN && run_in &&
        cur_ff.sh_cnt >= TMR_W'(SH_CYC)) |=> fault_out) // [R18]
        else $error("short not tripped");
    chk_open_trip: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (cur_ff.st == LCMFC_CH_RUN && run_in &&
        cur_ff.op_pulses >= 5'(DG_PULSES)) |=> fault_out) // [R19]
        else $error("open pulse count not tripped");
    chk_retest: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (fault_out && run_in && cur_ff.hc_cnt == TMR_W'(HC_CYC - 1))
        |=> (cur_ff.st == LCMFC_CH_RUN && cur_ff.ss_cnt == '0)) // [R15]
        else $error("no retest after hiccup");
endmodule // lcmfc_channel

// [src/lcmfc_pkg.sv]
// constants and types for the led channel mode and fault controller
// assumes a 10 mhz system clock; analog comparators deliver clean levels
package lcmfc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int SOFT_START_US = 200;
    localparam int SOFT_START_CYC = (SOFT_START_US * CLK_HZ) / 1_000_000;
    localparam int LOW_POWER_MS = 4;
    localparam int LOW_POWER_CYC = (LOW_POWER_MS * CLK_HZ) / 1000;
    localparam int HICCUP_MS = 128;
    localparam int HICCUP_CYC = (HICCUP_MS * CLK_HZ) / 1000;
    localparam int SHORT_DG_MS = 4;
    localparam int SHORT_DG_CYC = (SHORT_DG_MS * CLK_HZ) / 1000;
    localparam int OPEN_DG_MS = 6;
    localparam int OPEN_DG_CYC = (OPEN_DG_MS * CLK_HZ) / 1000;
    localparam int DG_PULSES = 15;
    localparam int RAMP_W = 8;
    localparam logic [7:0] RAMP_FULL = 8'hff;
    localparam int TMR_W = 24;
    typedef enum logic [1:0] {LCMFC_CH_OFF, LCMFC_CH_RUN, LCMFC_CH_HICCUP}
        lcmfc_ch_state_t;
endpackage

// [src/lcmfc_top.sv]
// led channel mode and fault controller top: enable, low power, headroom
// feedback and the shared open-drain fault line for NUM_CH channels, two by default
// assumes all inputs are synchronous to clk_sys_in and already filtered
`timescale 1ns/1ps
// Functional notes
// R1: enable on any dim high, off when all low; the code stays enabled with all dims low until low power is entered
// R2: ramp sink current over about 200 us
// R3: all dims quiet 4 ms enters low power
// R4: any dim activity wakes from low power
// R5: each sink follows its own dim input
// R6: handle dim high pulses down to 1 us
// R7: controller runs dimming above 500 Hz
// R8: static dim level keeps channel off or on
// R9: no feedback current if enabled channel lacks headroom
// R10: dim-low channel ignored for headroom reporting
// R11: feedback current when all headroom sufficient
// R12: supply lockout with 6 V on, 5.7 V off
// R13: lockout asserts the fault output
// R14: open or short: fault 128 ms then retest
// R15: retest passes reactivates, else repeat cycle
// R16: unaffected channels keep running during fault
// R17: all fault sources share one fault output
// R18: short confirmed after 4 ms or 15 cycles
// R19: open confirmed after 6 ms or 15 cycles
// R20: fault output is open drain, shareable
// R21: inactivity timer restarts on any dim high
// R22: fault released once no source remains
module lcmfc_top #(
    parameter int NUM_CH = 2,
    parameter int LP_CYC = lcmfc_pkg::LOW_POWER_CYC,
    parameter int HC_CYC = lcmfc_pkg::HICCUP_CYC,
    parameter int SH_CYC = lcmfc_pkg::SHORT_DG_CYC,
    parameter int OP_CYC = lcmfc_pkg::OPEN_DG_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [NUM_CH-1:0] channel_dim_input_in,
    input wire logic supply_above_on_in,
    input wire logic supply_above_off_in,
    input wire logic over_temp_in,
    input wire logic [NUM_CH-1:0] headroom_ok_in,
    input wire logic [NUM_CH-1:0] open_det_in,
    input wire logic [NUM_CH-1:0] short_det_in,
    output logic [NUM_CH-1:0] channel_current_sink_out,
    output logic [NUM_CH*lcmfc_pkg::RAMP_W-1:0] ramp_level_out,
    output logic headroom_feedback_current_out,
    output logic low_power_out,
    output logic enabled_out,
    output logic fault_out_n_out,
    output logic fault_out_n_oe_out
);
    import lcmfc_pkg::*;
    typedef struct packed {
        logic uv_lock;
        logic low_power;
        logic [TMR_W-1:0] idle_cnt;
        logic pg;
        logic fault;
    } lcmfc_top_t;
    lcmfc_top_t cur_ff, nxt_ff;
    logic any_dim;
    logic run;
    logic [NUM_CH-1:0] ch_fault;
    logic [NUM_CH-1:0] ch_sink;
    logic [NUM_CH-1:0] short_lack;

    // dim inputs are sampled every 100 ns, so a 1 us pulse is ten samples
    assign any_dim = |channel_dim_input_in; // [R1] [R6]
    assign run = !cur_ff.uv_lock && (any_dim || !cur_ff.low_power);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            lcmfc_channel #(
                .SS_CYC(SOFT_START_CYC),
                .SH_CYC(SH_CYC),
                .OP_CYC(OP_CYC),
                .HC_CYC(HC_CYC)
            ) u_ch (
                .clk_sys_in(clk_sys_in),
                .rst_n_in(rst_n_in),
                .run_in(run), // [R16]
                .dim_in(channel_dim_input_in[gi]),
                .open_det_in(open_det_in[gi]),
                .short_det_in(short_det_in[gi]),
                .sink_on_out(ch_sink[gi]),
                .ramp_level_out(ramp_level_out[gi*RAMP_W +: RAMP_W]),
                .fault_out(ch_fault[gi])
            );
            // a dim-low channel never counts as lacking headroom
            assign short_lack[gi] = channel_dim_input_in[gi] &&
                !headroom_ok_in[gi]; // [R10]
        end
    endgenerate

    always_comb
    begin
        nxt_ff = cur_ff;
        // hysteresis: lock until on level, relock below off level
        if (cur_ff.uv_lock && supply_above_on_in) // [R12]
        begin
            nxt_ff.uv_lock = 1'b0;
        end
        else if (!cur_ff.uv_lock && !supply_above_off_in) // [R12]
        begin
            nxt_ff.uv_lock = 1'b1;
        end
        if (any_dim) // [R21]
        begin
            nxt_ff.idle_cnt = '0;
            nxt_ff.low_power = 1'b0; // [R4]
        end
        else if (cur_ff.idle_cnt < TMR_W'(LP_CYC))
        begin
            nxt_ff.idle_cnt = cur_ff.idle_cnt + 1'b1;
        end
        else
        begin
            nxt_ff.low_power = 1'b1; // [R3]
        end
        // feedback only while the driver runs and no lit channel is short
        nxt_ff.pg = run && any_dim && (short_lack == '0); // [R9] [R11]
        nxt_ff.fault = nxt_ff.uv_lock || over_temp_in ||
            (ch_fault != '0); // [R13] [R17] [R22]
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // supply assumed low at power up, so lockout starts set
            cur_ff <= '{uv_lock: 1'b1, low_power: 1'b1, idle_cnt: '0,
                pg: 1'b0, fault: 1'b1};
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    assign channel_current_sink_out = ch_sink;
    assign headroom_feedback_current_out = cur_ff.pg;
    assign low_power_out = cur_ff.low_power;
    assign enabled_out = run; // [R1]
    // open drain: only ever pulls low; pull-up lives on the board
    assign fault_out_n_out = 1'b0; // [R20]
    assign fault_out_n_oe_out = cur_ff.fault; // [R20]

    chk_lp_entry: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (!any_dim && cur_ff.idle_cnt == TMR_W'(LP_CYC)) |=> low_power_out)
        // [R3]
        else $error("low power not entered");
    chk_lp_wake: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        any_dim |=> !low_power_out && cur_ff.idle_cnt == '0) // [R4]
        else $error("no wake on dim activity");
    chk_uv_fault: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        cur_ff.uv_lock |-> fault_out_n_oe_out) // [R13]
        else $error("lockout without fault");
    chk_uv_hyst: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (cur_ff.uv_lock && !supply_above_on_in) |=> cur_ff.uv_lock) // [R12]
        else $error("lockout released below on level");
    chk_pg_lack: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (short_lack != '0) |=> !headroom_feedback_current_out) // [R9]
        else $error("feedback despite low headroom");
    chk_fault_rel: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (!nxt_ff.uv_lock && !over_temp_in && ch_fault == '0)
        |=> !fault_out_n_oe_out) // [R22]
        else $error("fault held with no source");
    chk_ch_fault: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        $rose(ch_fault[0]) |=> fault_out_n_oe_out) // [R14]
        else $error("channel fault not reported");
    chk_idle_reset: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        $fell(any_dim) |=> cur_ff.idle_cnt == TMR_W'(1)) // [R21]
        else $error("idle timer not restarted");
endmodule // lcmfc_top

// [tb/lcmfc_mcu_model.sv]
// controller stand-in: per-channel pwm dims and the pulled-up fault line
// assumes the bench changes period and high counts on the falling edge
`timescale 1ns/1ps
module lcmfc_mcu_model #(
    parameter int NUM_CH = 2
) (
    input wire logic clk_sys_in,
    input wire logic [15:0] period_in,
    input wire logic [NUM_CH*16-1:0] high_cnt_in,
    input wire logic fault_data_in,
    input wire logic fault_oe_in,
    output logic [NUM_CH-1:0] dim_out,
    output wire logic fault_line_out
);
    logic [15:0] phase_ff;
    // the pull-up wins whenever no device drives the line
    assign fault_line_out = fault_oe_in ? fault_data_in : 1'b1;
    initial
    begin
        phase_ff = 16'h0000;
        dim_out = '0;
    end
    // a shared phase keeps both channels on one dimming period
    always @(negedge clk_sys_in)
    begin
        if (phase_ff + 16'h0001 >= period_in)
            phase_ff <= 16'h0000;
        else
            phase_ff <= phase_ff + 16'h0001;
        // a high count at or above the period holds the level static
        for (int i = 0; i < NUM_CH; i++)
            dim_out[i] <= phase_ff < high_cnt_in[i*16 +: 16];
    end
endmodule // lcmfc_mcu_model

// [tb/lcmfc_top_tb_top.sv]
// self-checking bench for the led channel mode and fault controller
// assumes lcmfc_mcu_model drives dims; long counts except the soft-start are cut by parameters
`timescale 1ns/1ps
module lcmfc_top_tb_top;
    import lcmfc_pkg::*;
    localparam int HC = 50;
    localparam int SH = 30;
    localparam int LP = 40;
    localparam logic [15:0] FULL = 16'hffff;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic up_on = 1'b0;
    logic up_off = 1'b0;
    logic otp = 1'b0;
    logic [1:0] hr = 2'h3;
    logic [1:0] opn = 2'h0;
    logic [1:0] sht = 2'h0;
    logic [31:0] hi = 32'h0;
    logic [1:0] dim;
    logic [1:0] sink;
    logic [15:0] ramp;
    logic pg, lp, en, f_d, f_oe;
    wire fl;
    int errors = 0;
    int num_checks = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    lcmfc_mcu_model #(.NUM_CH(2)) lcmfc_mcu_model_i (
        .clk_sys_in(clk_sys_in), .period_in(16'd20), .high_cnt_in(hi),
        .fault_data_in(f_d), .fault_oe_in(f_oe), .dim_out(dim),
        .fault_line_out(fl));
    lcmfc_top #(.NUM_CH(2), .LP_CYC(LP), .HC_CYC(HC), .SH_CYC(SH),
        .OP_CYC(40)) lcmfc_top_i (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .channel_dim_input_in(dim), .supply_above_on_in(up_on),
        .supply_above_off_in(up_off), .over_temp_in(otp),
        .headroom_ok_in(hr), .open_det_in(opn), .short_det_in(sht),
        .channel_current_sink_out(sink), .ramp_level_out(ramp),
        .headroom_feedback_current_out(pg), .low_power_out(lp),
        .enabled_out(en), .fault_out_n_out(f_d),
        .fault_out_n_oe_out(f_oe));
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // bounded wait: a fault that never lets go must not hang the run
    task automatic wait_rel(input int lim);
        int n;
        n = 0;
        while (fl !== 1'b1 && n < lim)
        begin
            w(1);
            n++;
        end
        check("fault released", 16'h1, 16'(fl));
    endtask
    task automatic t_supply;
        hi <= {FULL, FULL};
        w(10);
        check("fault in lockout", 16'h0, 16'(fl));
        check("sinks in lockout", 16'h0, 16'(sink));
        up_on <= 1'b1;
        up_off <= 1'b1;
        w(10);
        check("fault after lockout", 16'h1, 16'(fl));
        check("sinks after lockout", 16'h3, 16'(sink));
        up_on <= 1'b0;
        w(10);
        check("hysteresis band", 16'h1, 16'(fl));
        up_off <= 1'b0;
        w(5);
        check("fault below off", 16'h0, 16'(fl));
        check("sinks below off", 16'h0, 16'(sink));
        up_on <= 1'b1;
        up_off <= 1'b1;
        w(10);
        $display("test supply done");
    endtask
    task automatic t_lowpower;
        hi <= 32'h0;
        w(LP - 10);
        check("awake before quiet", 16'h0, 16'(lp));
        hi <= {16'h0, FULL};
        w(4);
        check("short pulse sink", 16'h1, 16'(sink));
        w(6);
        hi <= 32'h0;
        w(LP - 10);
        check("timer restarted", 16'h0, 16'(lp));
        w(15);
        check("low power entered", 16'h1, 16'(lp));
        check("disabled", 16'h0, 16'(en));
        $display("test low power done");
    endtask
    task automatic t_wake;
        hi <= {16'h0, FULL};
        w(5);
        check("woken", 16'h0, 16'(lp));
        check("enabled", 16'h1, 16'(en));
        check("ramp rising", 16'h1, 16'(ramp[7:0] != RAMP_FULL));
        w(2010);
        check("ramp full", 16'(RAMP_FULL), 16'(ramp[7:0]));
        check("dark ramp idle", 16'h0, 16'(ramp[15:8]));
        $display("test wake done");
    endtask
    task automatic t_headroom;
        hi <= {FULL, FULL};
        w(10);
        check("feedback on", 16'h1, 16'(pg));
        hr <= 2'h1;
        w(5);
        check("feedback off", 16'h0, 16'(pg));
        hi <= {16'h0, FULL};
        w(5);
        check("dark channel ignored", 16'h1, 16'(pg));
        check("own dim only", 16'h1, 16'(sink));
        hr <= 2'h3;
        hi <= {FULL, FULL};
        w(10);
        $display("test headroom done");
    endtask
    task automatic t_short;
        sht <= 2'h1;
        w(SH - 5);
        check("short not yet", 16'h1, 16'(fl));
        w(10);
        check("short fault", 16'h0, 16'(fl));
        check("sinks in hiccup", 16'h2, 16'(sink));
        w(HC + SH);
        check("retest failed", 16'h0, 16'(fl));
        sht <= 2'h0;
        wait_rel(HC + 20);
        w(5);
        check("channel back", 16'h3, 16'(sink));
        $display("test short done");
    endtask
    task automatic t_open;
        hi <= {16'd10, FULL};
        opn <= 2'h2;
        w(13 * 20);
        check("open not yet", 16'h1, 16'(fl));
        // the trip lands in the first half of this wait; the hiccup then
        // lasts HC cycles, so look well before the retest
        w(50);
        check("open fault", 16'h0, 16'(fl));
        check("other runs", 16'h1, 16'(sink[0]));
        opn <= 2'h0;
        wait_rel(HC + 60);
        $display("test open done");
    endtask
    task automatic t_otp;
        otp <= 1'b1;
        w(3);
        check("thermal fault", 16'h0, 16'(fl));
        otp <= 1'b0;
        w(3);
        check("thermal cleared", 16'h1, 16'(fl));
        $display("test thermal done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_supply();
        t_lowpower();
        t_wake();
        t_headroom();
        t_short();
        t_open();
        t_otp();
        final_report();
    end
    // the whole sequence needs well under 4000 cycles
    initial
    begin
        repeat (10000) @(posedge clk_sys_in);
        errors++;
        final_report();
    end
endmodule // lcmfc_top_tb_top
